/* xcvr_channel_clock_distribution.sv */
// transmit and receive clock selection for one transceiver channel
// assumes apb master on pclk; pll and clock-line rates arrive as
// one-cycle enable ticks on pclk, the receive serial line as a raw pin
//
// The implementer's own choices: the address map and the APB interface to the registers.

module xcvr_channel_clock_distribution
  import clkdist_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // transmit pll serial ticks on the local lines
  input  wire logic        bank_tx_pll_tick,
  input  wire logic        channel_multiplier_pll_tick,
  input  wire logic        frac_pll_tick,
  // bank and side clock lines
  input  wire logic        bank_line_ser_tick,
  input  wire logic        bank_line_par_tick,
  input  wire logic        side_line_ser_tick,
  input  wire logic        side_line_par_tick,
  // fabric core clock tick and receive serial pin
  input  wire logic        core_clk_tick,
  input  wire logic        rx_serial_in,
  // transmit clock enables
  output logic             ser_clk_en,
  output logic             par_clk_en,
  output logic             enc_clk_en,
  output logic             bser_rd_en,
  output logic             bser_wr_en,
  output logic             fifo_rd_en,
  output logic             fifo_wr_en,
  output logic             tx_fabric_clk_en,
  output logic             pll_fb_en,
  // receive clock enables
  output logic             cdr_enable,
  output logic             rx_ser_en,
  output logic             rx_par_rec_en,
  output logic             rx_pcs_en
);

  // configuration and run state
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic              run_r;
  logic              run_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;

  // activity counters
  logic [31:0] txcnt_r;
  logic [31:0] txcnt_nxt;
  logic [31:0] rxcnt_r;
  logic [31:0] rxcnt_nxt;

  // receive pin synchroniser and filtered level
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic rx_lvl_r;
  logic rx_lvl_nxt;
  logic rx_edge;

  // decoded configuration fields
  logic       byte_ser;
  logic       bonded;
  logic [1:0] line_sel;
  logic [1:0] pll_src;
  logic       pma_only;
  logic       hirate;
  logic       fb_comp;
  logic       cmu_own;
  logic       rx_div_sel;
  logic       same_bank;
  logic       host_div;
  logic       core_clk;

  // internal ticks and flags
  logic       ser_tick;
  logic       line_ser;
  logic       line_par;
  logic       own_par;
  logic       par_tick;
  logic       div2_tick;
  logic       rec_par;
  logic       pcs_on;
  logic       no_par;
  logic       fb_active;
  logic       cfg_err;
  logic       apb_wr;
  logic       apb_setup;
  logic       addr_ok;
  logic [31:0] status;

  assign byte_ser   = ctrl_r[CTRL_BYTE_SER];
  assign bonded     = ctrl_r[CTRL_BONDED];
  assign line_sel   = ctrl_r[CTRL_LINE_LO +: 2];
  assign pll_src    = ctrl_r[CTRL_PLL_LO +: 2];
  assign pma_only   = ctrl_r[CTRL_PMA_ONLY];
  assign hirate     = ctrl_r[CTRL_HIRATE];
  assign fb_comp    = ctrl_r[CTRL_FB_COMP];
  assign cmu_own    = ctrl_r[CTRL_CMU_OWN];
  assign rx_div_sel = ctrl_r[CTRL_RX_DIV];
  assign same_bank  = ctrl_r[CTRL_SAME_BANK];
  assign host_div   = ctrl_r[CTRL_HOST_DIV];
  assign core_clk   = ctrl_r[CTRL_CORE_CLK];

  // apb decode; the slave never waits, so pready is tied high
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign addr_ok   = (paddr == OFF_CTRL) || (paddr == OFF_RUN) ||
                     (paddr == OFF_STATUS) || (paddr == OFF_TXCNT) ||
                     (paddr == OFF_RXCNT);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign prdata    = prdata_r;

  // remote line: same bank takes the bank line, others the side line
  always_comb begin
    line_ser = 1'b0;
    line_par = 1'b0;
    if (line_sel == LINE_BANK || (line_sel == LINE_SIDE && same_bank)) begin
      line_ser = bank_line_ser_tick;
      line_par = bank_line_par_tick;
    end else if (line_sel == LINE_SIDE) begin
      line_ser = side_line_ser_tick;
      line_par = side_line_par_tick;
    end
  end

  // serial tick into this channel's divider
  always_comb begin
    ser_tick = 1'b0;
    if (run_r) begin
      if (line_sel == LINE_LOCAL && !bonded) begin
        case (pll_src)
          PLL_BANK_TX: ser_tick = bank_tx_pll_tick;
          PLL_CMU:     ser_tick = channel_multiplier_pll_tick;
          PLL_FRAC:    ser_tick = frac_pll_tick;
          default:     ser_tick = 1'b0;
        endcase
      end else begin
        ser_tick = line_ser;
      end
    end
  end

  // non-bonded channels build their own parallel clock
  tick_divider u_ser_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!run_r),
    .ratio   (SER_DIV),
    .tick    (ser_tick),
    .pulse   (own_par)
  );

  // divider host on the side line cannot make a parallel clock unbonded
  assign no_par = !bonded && line_sel == LINE_SIDE && host_div;

  // bonded channels take the line's parallel clock as it stands
  always_comb begin
    par_tick = 1'b0;
    if (run_r && !no_par) begin
      par_tick = bonded ? line_par : own_par;
    end
  end

  // half-rate tick for byte serializer write and fifo read
  tick_divider u_bser_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!run_r || !byte_ser),
    .ratio   (byte_ser ? BSER_ON : BSER_OFF),
    .tick    (par_tick),
    .pulse   (div2_tick)
  );

  // transmit pcs blocks sit idle when the fabric talks to the pma directly
  assign pcs_on     = !pma_only;
  assign ser_clk_en = ser_tick;
  assign par_clk_en = par_tick;
  assign enc_clk_en = pcs_on && par_tick;
  assign bser_rd_en = pcs_on && !hirate && par_tick;
  assign bser_wr_en = pcs_on && !hirate &&
                      (byte_ser ? div2_tick : par_tick);

  // high-rate pcs has no byte serializer and reads the fifo undivided
  assign fifo_rd_en = pcs_on && ((hirate || !byte_ser) ? par_tick
                                                        : div2_tick);

  // forwarded fabric clock follows the fifo read side or the pma
  assign tx_fabric_clk_en = pma_only ? par_tick : fifo_rd_en;

  // fabric write side picks forwarded or its own core clock
  assign fifo_wr_en = pcs_on &&
                      (core_clk ? core_clk_tick : tx_fabric_clk_en);

  // fractional pll offers no feedback path, so it stays off then
  assign fb_active = run_r && bonded && fb_comp &&
                     pll_src != PLL_FRAC;
  assign pll_fb_en = fb_active && par_tick;

  // settings that no path can honour
  assign cfg_err = (fb_comp && pll_src == PLL_FRAC) ||
                   (fb_comp && !bonded) ||
                   (bonded && line_sel == LINE_LOCAL) ||
                   (line_sel == 2'h3) || (pll_src == 2'h3);

  // three-stage pin synchroniser; only a settled level is believed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= rx_serial_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // level changes once stages two and three agree
  always_comb begin
    rx_lvl_nxt = rx_lvl_r;
    if (sync2_r == sync3_r) begin
      rx_lvl_nxt = sync3_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_lvl_r <= 1'b0;
    end else begin
      rx_lvl_r <= rx_lvl_nxt;
    end
  end

  // channel pll busy as transmit multiplier leaves no recovery
  assign cdr_enable = run_r && !cmu_own;
  assign rx_edge    = rx_lvl_nxt != rx_lvl_r;
  assign rx_ser_en  = cdr_enable && rx_edge;

  // recovered parallel clock is the recovered serial clock divided
  tick_divider u_rec_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (!cdr_enable),
    .ratio   (SER_DIV),
    .tick    (rx_ser_en),
    .pulse   (rec_par)
  );

  assign rx_par_rec_en = cdr_enable && rec_par;
  assign rx_pcs_en     = cdr_enable &&
                         (rx_div_sel ? par_tick : rec_par);

  // status word built from live state
  always_comb begin
    status             = 32'h0000_0000;
    status[ST_RUN]     = run_r;
    status[ST_CDR]     = cdr_enable;
    status[ST_TX_ONLY] = cmu_own;
    status[ST_FB]      = fb_active;
    status[ST_PLL_USE] = fb_active;
    status[ST_CFG_ERR] = cfg_err;
    status[ST_NO_PAR]  = no_par;
    status[ST_RX_LVL]  = rx_lvl_r;
  end

  // register writes; clock settings only change while run is low
  always_comb begin
    ctrl_nxt   = ctrl_r;
    run_nxt    = run_r;
    prdata_nxt = prdata_r;
    if (apb_wr && paddr == OFF_CTRL && !run_r) begin
      ctrl_nxt = pwdata[CTRL_W-1:0];
    end
    if (apb_wr && paddr == OFF_RUN) begin
      run_nxt = pwdata[0];
    end
    // read data is captured in setup so it comes from a flop
    if (apb_setup && !pwrite) begin
      case (paddr)
        OFF_CTRL:   prdata_nxt = {{(32-CTRL_W){1'b0}}, ctrl_r};
        OFF_RUN:    prdata_nxt = {31'h0000_0000, run_r};
        OFF_STATUS: prdata_nxt = status;
        OFF_TXCNT:  prdata_nxt = txcnt_r;
        OFF_RXCNT:  prdata_nxt = rxcnt_r;
        default:    prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= CTRL_RESET;
      run_r    <= RUN_RESET;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      run_r    <= run_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // tick counters let software see the clocks really run; wrap freely
  always_comb begin
    txcnt_nxt = txcnt_r;
    rxcnt_nxt = rxcnt_r;
    if (!run_r) begin
      txcnt_nxt = 32'h0000_0000;
      rxcnt_nxt = 32'h0000_0000;
    end else begin
      if (tx_fabric_clk_en) begin
        txcnt_nxt = txcnt_r + 32'h0000_0001;
      end
      if (rx_pcs_en) begin
        rxcnt_nxt = rxcnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcnt_r <= 32'h0000_0000;
      rxcnt_r <= 32'h0000_0000;
    end else begin
      txcnt_r <= txcnt_nxt;
      rxcnt_r <= rxcnt_nxt;
    end
  end

endmodule

/* clkdist_pkg.sv */
// constants for the transceiver channel clock distribution block
// assumes a single 100 MHz pclk; pll and line rates arrive as enable ticks, the receive line as a raw pin
package clkdist_pkg;

  // apb register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_RUN    = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_TXCNT  = 5'h0c;
  localparam logic [4:0] OFF_RXCNT  = 5'h10;

  // control register field positions
  localparam int CTRL_BYTE_SER  = 0;
  localparam int CTRL_BONDED    = 1;
  localparam int CTRL_LINE_LO   = 2;
  localparam int CTRL_PLL_LO    = 4;
  localparam int CTRL_PMA_ONLY  = 6;
  localparam int CTRL_HIRATE    = 7;
  localparam int CTRL_FB_COMP   = 8;
  localparam int CTRL_CMU_OWN   = 9;
  localparam int CTRL_RX_DIV    = 10;
  localparam int CTRL_SAME_BANK = 11;
  localparam int CTRL_HOST_DIV  = 12;
  localparam int CTRL_CORE_CLK  = 13;
  localparam int CTRL_W         = 14;

  // status register field positions
  localparam int ST_RUN     = 0;
  localparam int ST_CDR     = 1;
  localparam int ST_TX_ONLY = 2;
  localparam int ST_FB      = 3;
  localparam int ST_PLL_USE = 4;
  localparam int ST_CFG_ERR = 5;
  localparam int ST_NO_PAR  = 6;
  localparam int ST_RX_LVL  = 7;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
  localparam logic              RUN_RESET  = 1'b0;

  // clock line choice
  localparam logic [1:0] LINE_LOCAL = 2'h0;
  localparam logic [1:0] LINE_BANK  = 2'h1;
  localparam logic [1:0] LINE_SIDE  = 2'h2;

  // transmit pll source
  localparam logic [1:0] PLL_BANK_TX = 2'h0;
  localparam logic [1:0] PLL_CMU     = 2'h1;
  localparam logic [1:0] PLL_FRAC    = 2'h2;

  // divide counts: serial ticks per parallel tick, byte serializer factors
  localparam logic [3:0] SER_DIV = 4'ha;
  localparam logic [3:0] BSER_OFF = 4'h1;
  localparam logic [3:0] BSER_ON  = 4'h2;

endpackage

/* tick_divider.sv */
// divide an enable tick stream by a programmable ratio
// assumes tick is a one-cycle pulse in the pclk domain
module tick_divider
  import clkdist_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       clear,
  input  wire logic [3:0] ratio,
  // tick in, divided tick out
  input  wire logic       tick,
  output logic            pulse
);

  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic       pulse_r;
  logic       pulse_nxt;

  // count input ticks, emit one pulse per ratio ticks
  always_comb begin
    count_nxt = count_r;
    pulse_nxt = 1'b0;
    if (clear) begin
      count_nxt = 4'h0;
    end else if (tick) begin
      if (count_r >= ratio - 4'h1) begin
        count_nxt = 4'h0;
        pulse_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 4'h0;
      pulse_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule

/* fabric_model.sv */
// fabric-side user logic: core clock source and fifo write side
// assumes one pclk; counts clear while en is low
module fabric_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench control
  input  wire logic en,
  input  wire logic use_core,
  // channel side
  input  wire logic tx_fabric_clk_en,
  output logic      core_clk_tick,
  output int        wr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;
  // core clock ticks every third cycle, and only while enabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 2'h0;
      core_clk_tick <= 1'b0;
      wr_n <= 0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      core_clk_tick <= en && (ph == 2'h0);
      // one write per edge of the clock the fabric picked
      if (!en)
        wr_n <= 0;
      else if (use_core ? core_clk_tick : tx_fabric_clk_en)
        wr_n <= wr_n + 1;
    end
  end
endmodule

/* clkdist_props.sv */
// port-level relations of the channel clock enables
// assumes bind onto the block; enables other than cdr_enable are one-cycle pulses, cdr_enable is a level
module clkdist_props
  import clkdist_pkg::*;
(
  // clock, reset and apb
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [4:0] paddr,
  input wire logic       pslverr,
  // sources
  input wire logic       bank_tx_pll_tick,
  input wire logic       channel_multiplier_pll_tick,
  input wire logic       frac_pll_tick,
  input wire logic       bank_line_ser_tick,
  input wire logic       bank_line_par_tick,
  input wire logic       side_line_ser_tick,
  input wire logic       side_line_par_tick,
  input wire logic       core_clk_tick,
  // enables
  input wire logic       ser_clk_en,
  input wire logic       par_clk_en,
  input wire logic       enc_clk_en,
  input wire logic       bser_rd_en,
  input wire logic       bser_wr_en,
  input wire logic       fifo_rd_en,
  input wire logic       fifo_wr_en,
  input wire logic       tx_fabric_clk_en,
  input wire logic       pll_fb_en,
  input wire logic       cdr_enable,
  input wire logic       rx_ser_en,
  input wire logic       rx_par_rec_en,
  input wire logic       rx_pcs_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase of a transfer
  sequence apb_acc;
    psel && penable;
  endsequence
  sequence bad_acc;
    apb_acc ##0 (paddr > OFF_RXCNT);
  endsequence
  err_map_a: assert property (bad_acc |-> pslverr)
    else $error("unmapped access without error");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  ser_src_a: assert property (ser_clk_en |->
    bank_tx_pll_tick || channel_multiplier_pll_tick || frac_pll_tick ||
    bank_line_ser_tick || side_line_ser_tick)
    else $error("serial enable without source");
  par_src_a: assert property (par_clk_en |->
    $past(ser_clk_en) || bank_line_par_tick || side_line_par_tick)
    else $error("parallel enable without cause");
  enc_par_a: assert property (enc_clk_en || bser_rd_en |-> par_clk_en)
    else $error("encoder off the parallel clock");
  bser_fifo_a: assert property (bser_wr_en |-> fifo_rd_en)
    else $error("byte serializer and fifo read differ");
  fab_fwd_a: assert property (fifo_rd_en |-> tx_fabric_clk_en)
    else $error("fifo read clock not forwarded");
  fab_src_a: assert property (tx_fabric_clk_en |->
    fifo_rd_en || par_clk_en)
    else $error("fabric clock without cause");
  fifo_wr_a: assert property (fifo_wr_en |->
    tx_fabric_clk_en || core_clk_tick)
    else $error("fifo write off the fabric clocks");
  fb_par_a: assert property (pll_fb_en |-> par_clk_en)
    else $error("feedback without parallel clock");
  rx_par_a: assert property (rx_par_rec_en |-> $past(rx_ser_en))
    else $error("recovered parallel without serial");
  rx_pcs_a: assert property (rx_pcs_en |->
    rx_par_rec_en || par_clk_en)
    else $error("receive pcs clock without source");
  cdr_static_a: assert property ($changed(cdr_enable) |->
    $past(psel) && $past(penable) && $past(pwrite) &&
    $past(paddr) == OFF_RUN)
    else $error("recovery enable changed without run write");
  rst_idle_a: assert property ($rose(presetn) |->
    (!ser_clk_en && !par_clk_en && !cdr_enable) [*2])
    else $error("clocks active before run");
endmodule

bind xcvr_channel_clock_distribution clkdist_props clkdist_props_i (.*);

/* tb_top.sv */
// bench for the channel clock distribution block
// assumes 100 MHz pclk; a count model checks pulses per config
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  import clkdist_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, rx, en, uc;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er, core_clk_tick;
  logic [6:0]  tk;
  logic        ser_clk_en, par_clk_en, enc_clk_en, bser_rd_en;
  logic        bser_wr_en, fifo_rd_en, fifo_wr_en, tx_fabric_clk_en;
  logic        pll_fb_en, cdr_enable, rx_ser_en, rx_par_rec_en, rx_pcs_en;
  logic [11:0] o;
  int          cnt[12], src[7], wr_n, fail_count, check_count, cyc, seed;
  // placement of every row but the last keeps the channel limits
  // single-bank, matched reference rows only
  // last row asks feedback of the fractional pll, which must refuse it
  localparam logic [13:0] TC [16] = '{14'h0000, 14'h0001, 14'h0010,
    14'h0020, 14'h0004, 14'h0008, 14'h0808, 14'h1008, 14'h0006,
    14'h0106, 14'h0040, 14'h0080, 14'h2000, 14'h0410, 14'h0210, 14'h0126};
  // serial source index; parallel: 7 own divider, 8 none
  localparam int TS [16] = '{0, 0, 1, 2, 3, 5, 3, 5, 3, 3, 0, 0, 0, 1, 1,
    3};
  localparam int TP [16] = '{7, 7, 7, 7, 7, 7, 7, 8, 4, 4, 7, 7, 7, 7, 7,
    4};

  xcvr_channel_clock_distribution xcvr_channel_clock_distribution_i (
    .bank_tx_pll_tick(tk[0]), .channel_multiplier_pll_tick(tk[1]), .frac_pll_tick(tk[2]),
    .bank_line_ser_tick(tk[3]), .bank_line_par_tick(tk[4]),
    .side_line_ser_tick(tk[5]), .side_line_par_tick(tk[6]),
    .rx_serial_in(rx), .*);
  fabric_model fabric_model_i (.pclk(pclk), .presetn(presetn), .en(en),
    .use_core(uc), .tx_fabric_clk_en(tx_fabric_clk_en),
    .core_clk_tick(core_clk_tick), .wr_n(wr_n));

  assign o = {rx_pcs_en, rx_par_rec_en, rx_ser_en, pll_fb_en,
    tx_fabric_clk_en, fifo_wr_en, fifo_rd_en, bser_wr_en, bser_rd_en,
    enc_clk_en, par_clk_en, ser_clk_en};

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // pulse counters, sampled before the edge's updates land
  always @(posedge pclk) begin
    for (int k = 0; k < 12; k++) cnt[k] += o[k];
    for (int k = 0; k < 7; k++) src[k] += tk[k];
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; holds the request until pready at an edge
  task automatic apb(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one configuration: run ticks, compare counts with the model
  task automatic cfg(input logic [13:0] c, input int s, input int p);
    int n, pp, dv, fab, tg, rxp;
    logic fb;
    fb = c[8] && (c[5:4] != 2'h2);
    apb(1'b1, OFF_CTRL, {18'h0, c}, rd, er);
    uc <= c[13];
    apb(1'b1, OFF_RUN, 32'h1, rd, er);
    cnt = '{default: 0};
    src = '{default: 0};
    tg = 0;
    en <= 1'b1;
    for (int i = 0; i < 240; i++) begin
      @(posedge pclk);
      tk <= 7'($random(seed));
      if (i % 7 == 0) begin
        rx <= ~rx;
        tg++;
      end
    end
    @(posedge pclk);
    tk <= 7'h00;
    repeat (10) @(posedge pclk);
    // let this edge's updates land so counts and wr_n line up
    en <= 1'b0;
    @(negedge pclk);
    n = src[s];
    pp = (p == 7) ? n / 10 : (p == 8) ? 0 : src[p];
    dv = c[0] ? pp / 2 : pp;
    fab = c[6] ? pp : c[7] ? pp : dv;
    tg = c[9] ? 0 : tg;
    rxp = c[10] ? pp : tg / 10;
    `CHK(cnt[0], n)
    `CHK(cnt[1], pp)
    `CHK(cnt[2], c[6] ? 0 : pp)
    `CHK(cnt[3], (c[6] || c[7]) ? 0 : pp)
    `CHK(cnt[4], (c[6] || c[7]) ? 0 : dv)
    `CHK(cnt[5], c[6] ? 0 : fab)
    `CHK(cnt[6], c[6] ? 0 : wr_n)
    `CHK(cnt[7], fab)
    `CHK(cnt[8], fb ? pp : 0)
    `CHK(cnt[9], tg)
    `CHK(cnt[10], tg / 10)
    `CHK(cnt[11], rxp)
    `CHK(cdr_enable, ~c[9])
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    `CHK(rd[ST_TX_ONLY], c[9])
    `CHK(rd[ST_PLL_USE], fb)
    `CHK(rd[ST_CFG_ERR], c[8] && !fb)
    `CHK(rd[ST_NO_PAR], p == 8)
    apb(1'b0, OFF_TXCNT, 32'h0, rd, er);
    `CHK(rd, 32'(fab))
    apb(1'b1, OFF_CTRL, 32'h3fff, rd, er);
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, {18'h0, c})
    apb(1'b1, OFF_RUN, 32'h0, rd, er);
    $display("config %h done", c);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pwdata = 32'h0;
    tk = 7'h00;
    rx = 1'b0;
    en = 1'b0;
    uc = 1'b0;
    seed = 32'h997a;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and the unmapped hole
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    apb(1'b0, OFF_RUN, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    apb(1'b0, 5'h1c, 32'h0, rd, er);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    $display("reset test done");
    for (int k = 0; k < 16; k++) cfg(TC[k], TS[k], TP[k]);
    // reset in mid-run must drop run and configuration
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    apb(1'b1, OFF_RUN, 32'h1, rd, er);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_RUN, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    apb(1'b0, OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    $display("mid-run reset test done");
    close_out();
  end
endmodule
